// file: core/mmbx_consts.svh
// Constants for the move, branch and memory micro executor
`ifndef MMBX_CONSTS_SVH
`define MMBX_CONSTS_SVH
// Opcode nibble, instruction bits 15:12
`define MMBX_OP_RMOVE   4'h1
`define MMBX_OP_SPMOVE  4'h2
`define MMBX_OP_MANIP   4'h3
`define MMBX_OP_BRF     4'h4
`define MMBX_OP_BRT     4'h5
`define MMBX_OP_SKIP    4'h6
`define MMBX_OP_MEM     4'h7
`define MMBX_OP_LIT8    4'h8
`define MMBX_OP_LIT24   4'h9
// Register index is group*4 + select
`define MMBX_IDX_CARRY  6'h15
`define MMBX_IDX_CMP    6'h29
`define MMBX_IDX_OPST   6'h2D
`define MMBX_IDX_PORT   6'h31
`define MMBX_IDX_FLEN   6'h35
`define MMBX_IDX_U      6'h27
`define MMBX_IDX_DATA   6'h2F
`define MMBX_IDX_PORT_COMMAND_REG   6'h33
`define MMBX_IDX_CSW    6'h36
`define MMBX_IDX_TIMR   6'h3A
`define MMBX_IDX_M      6'h3E
// Field lengths
`define MMBX_FL_FULL    5'h18
`define MMBX_FL_NOLOG   5'h19
`define MMBX_FL_BADECC  5'h1A
// Register bus offsets and reset values
`define MMBX_OFS_CTRL   5'h00
`define MMBX_OFS_CPL    5'h04
`define MMBX_OFS_PC     5'h08
`define MMBX_OFS_STAT   5'h0C
`define MMBX_OFS_DIDX   5'h10
`define MMBX_OFS_DDATA  5'h14
`define MMBX_CPL_RST    5'h18
`define MMBX_PC_RST     16'h0000
`endif

// file: core/mmbx_pkg.sv
// Types for the move, branch and memory micro executor
package mmbx_pkg;
  typedef enum logic [0:0] {MMBX_IDLE, MMBX_MEMW} mmbx_state_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [31:0] wdata;
  } mmbx_bus_t;
  typedef struct packed {
    logic [3:0] carry;
    logic [3:0] compare;
    logic [3:0] opstate;
    logic [3:0] flen;
    logic [3:0] port;
  } mmbx_cond_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        dir;
    logic [4:0]  len;
    logic [23:0] addr;
    logic [23:0] data;
    logic        no_log;
    logic        bad_ecc;
  } mmbx_mem_t;
endpackage

// file: core/mmbx_exec.sv
// Executor for register, scratchpad, manipulate, branch, skip, memory and literal micros
//
// Contract
// RQ1 - Narrow to wide move zero-extends
// RQ2 - Wide to narrow move drops high bits
// RQ3 - M destination ORs into next micro
// RQ4 - Condition, status, result, U not destinations
// RQ5 - Command register never a move source
// RQ6 - Data source forbids command, data destinations
// RQ7 - U source rejected in step mode
// RQ8 - Timer never source or sink of move; scratchpad moves do not check it
// RQ9 - Scratchpad move by direction and word bits
// RQ10 - Manipulate keeps condition regs, still skips
// RQ11 - Branch false jumps when bit zero
// RQ12 - Branch true jumps when bit one
// RQ13 - Zero mask skips for 001 011 100
// RQ14 - Zero mask no skip 000 101 111
// RQ15 - Condition regs testable, never cleared
// RQ16 - Short field: zero-fill read, truncate write
// RQ17 - Address from FA, zero length uses CURRENT_PRECISION_LENGTH
// RQ18 - Lengths 25, 26 act as 24; 25 no log
// RQ19 - Length 26 also forces bad check bits
// RQ20 - Literal8 zero-extends, timer clears, CONTROL_STATUS_WORD rejected
// RQ21 - Literal24 low part from next word
// RQ22 - Literal to timer clears it
// RQ23 - Skip steps one micro, literal word too
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "mmbx_consts.svh"
module mmbx_exec #(
  parameter int REGS  = 64,
  parameter int SPADS = 16
) (
  input  wire logic               clk_sys_i,
  input  wire logic               reset_n_i,
  input  wire logic               instr_valid_i,
  input  wire logic [15:0]        instr_i,
  input  wire logic [15:0]        literal_i,
  input  wire mmbx_pkg::mmbx_cond_t cond_i,
  input  wire logic               mem_ack_i,
  input  wire logic [23:0]        mem_rdata_i,
  input  wire mmbx_pkg::mmbx_bus_t  bus_i,
  output logic [31:0]             bus_rdata_o,
  output mmbx_pkg::mmbx_mem_t     mem_req_o,
  output logic [15:0]             pc_o,
  output logic                    busy_o,
  output logic                    reject_o,
  output logic                    skip_o,
  output logic                    carry_o,
  output logic                    borrow_o
);
  // ==========================================================
  // Register classes
  function automatic logic is_cond(input logic [5:0] i);
    return i == `MMBX_IDX_CARRY || i == `MMBX_IDX_CMP || i == `MMBX_IDX_OPST ||
           i == `MMBX_IDX_PORT || i == `MMBX_IDX_FLEN;
  endfunction
  function automatic logic no_dest(input logic [5:0] i);
    return is_cond(i) || i == `MMBX_IDX_CSW || i == `MMBX_IDX_U ||
           (i[1:0] == 2'h3 && i[5] == 1'b0);
  endfunction
  function automatic logic [4:0] reg_width(input logic [5:0] i);
    if (is_cond(i) || (i[5:4] == 2'h3 && i[1:0] == 2'h0))
      return 5'h04;
    if (i == `MMBX_IDX_M)
      return 5'h10;
    return 5'h18;
  endfunction
  // Right-justify and cut to w bits; w of 24 keeps everything
  function automatic logic [23:0] fit(input logic [23:0] v, input logic [4:0] w);
    logic [23:0] one;
    one = 24'h000001;
    return v & ((one << w) - 24'h000001);
  endfunction
  // ==========================================================
  // State
  logic [23:0]         regs_mem [REGS];
  logic [23:0]         spad_mem [2*SPADS];
  mmbx_pkg::mmbx_state_t state_reg;
  logic [15:0]         pc_reg;
  logic [15:0]         m_or_reg;
  logic                step_reg;
  logic [4:0]          cpl_reg;
  logic [5:0]          didx_reg;
  logic [7:0]          rej_cnt_reg;
  logic [5:0]          mem_idx_reg;
  logic [4:0]          mem_len_reg;

  function automatic logic [23:0] rd(input logic [5:0] i);
    case (i)
      `MMBX_IDX_CARRY: return {20'h00000, cond_i.carry};
      `MMBX_IDX_CMP:   return {20'h00000, cond_i.compare};
      `MMBX_IDX_OPST:  return {20'h00000, cond_i.opstate};
      `MMBX_IDX_FLEN:  return {20'h00000, cond_i.flen};
      `MMBX_IDX_PORT:  return {20'h00000, cond_i.port};
      default:         return regs_mem[i];
    endcase
  endfunction

  // ==========================================================
  // Decode
  logic        accept;
  logic [15:0] cur;
  logic [3:0]  op;
  logic [5:0]  dst;
  logic [5:0]  src;
  logic [15:0] pc_inc;
  assign accept = state_reg == mmbx_pkg::MMBX_IDLE && instr_valid_i;
  assign cur    = instr_i | m_or_reg; // see RQ3
  assign op     = cur[15:12];
  assign dst    = cur[11:6];
  assign src    = cur[5:0];
  assign pc_inc = pc_reg + 16'h0001;
  assign pc_o   = pc_reg;

  logic        wr_en;
  logic [5:0]  wr_idx;
  logic [23:0] wr_val;
  logic        sp_we;
  logic [4:0]  sp_adr;
  logic        skip;
  logic        rej;
  logic        mem_go;
  logic        cy;
  logic        bw;
  logic [15:0] pc_next;
  logic [4:0]  res5;
  logic [3:0]  nib;
  logic [3:0]  msk;
  logic        any_b;
  logic        all_b;
  logic        clr;
  logic [5:0]  idx6;
  logic [4:0]  len_eff;
  logic [23:0] bitv;

  always_comb begin
    wr_en   = 1'b0;
    wr_idx  = dst;
    wr_val  = 24'h000000;
    sp_we   = 1'b0;
    sp_adr  = {cur[3:0], cur[4]};
    skip    = 1'b0;
    rej     = 1'b0;
    mem_go  = 1'b0;
    cy      = 1'b0;
    bw      = 1'b0;
    pc_next = pc_inc;
    res5    = 5'h00;
    nib     = 4'(rd(dst));
    msk     = cur[11:8];
    idx6    = {cur[4:1], 1'b0, cur[0]};
    any_b   = 1'b0;
    all_b   = 1'b0;
    clr     = 1'b0;
    len_eff = (cur[4:0] == 5'h00) ? cpl_reg : cur[4:0]; // see RQ17
    if (len_eff > `MMBX_FL_FULL)
      len_eff = `MMBX_FL_FULL; // see RQ18
    bitv    = rd(dst) >> cur[5:4];
    if (state_reg == mmbx_pkg::MMBX_MEMW && mem_ack_i) begin
      wr_en  = !mem_req_o.write;
      wr_idx = mem_idx_reg;
      wr_val = fit(fit(mem_rdata_i, mem_len_reg), reg_width(mem_idx_reg)); // see RQ16
    end else if (accept) begin
      case (op)
        `MMBX_OP_RMOVE: begin
          rej = src == `MMBX_IDX_PORT_COMMAND_REG || no_dest(dst) ||               // see RQ4, RQ5
                (src == `MMBX_IDX_DATA &&
                 (dst == `MMBX_IDX_PORT_COMMAND_REG || dst == `MMBX_IDX_DATA)) ||   // see RQ6
                (step_reg && src == `MMBX_IDX_U) ||                     // see RQ7
                src == `MMBX_IDX_TIMR || dst == `MMBX_IDX_TIMR;         // see RQ8
          wr_en  = !rej;
          wr_val = fit(rd(src), reg_width(dst)); // see RQ1, RQ2
        end
        `MMBX_OP_SPMOVE: begin
          sp_adr = {cur[3:0], cur[4]};
          if (cur[5]) begin
            rej    = no_dest(dst); // see RQ4
            wr_en  = !rej;
            wr_val = fit(spad_mem[sp_adr], reg_width(dst)); // see RQ9
          end else begin
            rej   = dst == `MMBX_IDX_PORT_COMMAND_REG ||
                    (step_reg && dst == `MMBX_IDX_U); // see RQ5, RQ7
            sp_we = !rej; // see RQ9
          end
        end
        `MMBX_OP_MANIP: begin
          case (cur[5:4])
            2'h0: res5 = {1'b0, cur[3:0]};
            2'h1: res5 = {1'b0, nib} + {1'b0, cur[3:0]};
            2'h2: res5 = {1'b0, nib} - {1'b0, cur[3:0]};
            default: res5 = {1'b0, nib ^ cur[3:0]};
          endcase
          cy     = cur[5:4] == 2'h1 && res5[4];
          bw     = cur[5:4] == 2'h2 && res5[4];
          skip   = cy || bw;
          wr_en  = !is_cond(dst); // see RQ10
          wr_val = {20'h00000, res5[3:0]};
        end
        `MMBX_OP_BRF, `MMBX_OP_BRT: begin
          rej = dst == `MMBX_IDX_TIMR;
          if (!rej && (bitv[0] == (op == `MMBX_OP_BRT))) begin
            pc_next = pc_inc + {{12{cur[3]}}, cur[3:0]}; // see RQ11, RQ12
          end
        end
        `MMBX_OP_SKIP: begin
          nib   = 4'(rd(idx6));
          any_b = |(nib & msk);
          all_b = &(nib | ~msk);
          case (cur[7:5])
            3'h0: skip = any_b;
            3'h1: skip = !any_b;
            3'h2: skip = !any_b;
            3'h3: skip = all_b;
            3'h4: skip = all_b;
            3'h5: skip = any_b;
            3'h6: skip = !all_b;
            default: skip = !all_b;
          endcase // see RQ13, RQ14
          clr    = cur[7:5] == 3'h2 || cur[7:5] == 3'h4 ||
                   cur[7:5] == 3'h5 || cur[7:5] == 3'h6;
          wr_idx = idx6;
          wr_en  = clr && !is_cond(idx6); // see RQ15
          wr_val = {20'h00000, nib & ~msk};
        end
        `MMBX_OP_MEM: begin
          wr_idx = {cur[9:6], 1'b1, cur[5]};
          rej    = !cur[11] && no_dest(wr_idx);
          mem_go = !rej;
        end
        `MMBX_OP_LIT8: begin
          wr_idx = {cur[11:8], 2'h2};
          rej    = wr_idx == `MMBX_IDX_CSW; // see RQ20
          wr_en  = !rej;
          wr_val = (wr_idx == `MMBX_IDX_TIMR) ? 24'h000000 :
                   fit({16'h0000, cur[7:0]}, reg_width(wr_idx)); // see RQ20, RQ22
        end
        `MMBX_OP_LIT24: begin
          wr_idx  = {cur[11:8], 2'h2};
          rej     = wr_idx == `MMBX_IDX_CSW || wr_idx == `MMBX_IDX_M; // see RQ21
          wr_en   = !rej;
          wr_val  = (wr_idx == `MMBX_IDX_TIMR) ? 24'h000000 :
                    fit({cur[7:0], literal_i}, reg_width(wr_idx)); // see RQ21, RQ22
          pc_next = pc_reg + 16'h0002; // see RQ23
        end
        default: begin
        end
      endcase
      if (skip)
        pc_next = pc_inc + 16'h0001; // see RQ23
    end
  end

  // ==========================================================
  // Sequencer and memory port
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_reg   <= mmbx_pkg::MMBX_IDLE;
      pc_reg      <= `MMBX_PC_RST;
      mem_req_o   <= '0;
      mem_idx_reg <= 6'h00;
      mem_len_reg <= 5'h00;
      busy_o      <= 1'b0;
    end else begin
      if (accept && mem_go) begin
        state_reg          <= mmbx_pkg::MMBX_MEMW;
        busy_o             <= 1'b1;
        mem_idx_reg        <= wr_idx;
        mem_len_reg        <= len_eff;
        mem_req_o.valid    <= 1'b1;
        mem_req_o.write    <= cur[11];
        mem_req_o.dir      <= cur[10];
        mem_req_o.len      <= len_eff;
        mem_req_o.addr     <= regs_mem[6'h1E]; // see RQ17
        mem_req_o.data     <= fit(rd(wr_idx), len_eff); // see RQ16
        mem_req_o.no_log   <= cur[11] && (cur[4:0] == `MMBX_FL_NOLOG ||
                                           cur[4:0] == `MMBX_FL_BADECC); // see RQ18
        mem_req_o.bad_ecc  <= cur[11] && cur[4:0] == `MMBX_FL_BADECC; // see RQ19
      end else if (accept) begin
        pc_reg <= pc_next;
      end else if (state_reg == mmbx_pkg::MMBX_MEMW && mem_ack_i) begin
        state_reg       <= mmbx_pkg::MMBX_IDLE;
        busy_o          <= 1'b0;
        mem_req_o.valid <= 1'b0;
        pc_reg          <= pc_inc;
      end else if (bus_i.wr && bus_i.addr == `MMBX_OFS_PC && !busy_o) begin
        pc_reg <= bus_i.wdata[15:0];
      end
    end
  end

  // ==========================================================
  // Register file, scratchpad and the pending OR into M
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      for (int k = 0; k < REGS; k++)
        regs_mem[k] <= 24'h000000;
      for (int k = 0; k < 2*SPADS; k++)
        spad_mem[k] <= 24'h000000;
      m_or_reg <= 16'h0000;
    end else begin
      if (accept)
        m_or_reg <= 16'h0000;
      // M is not stored; the value shapes the next accepted micro, and its low byte reads back in STAT
      if (wr_en && wr_idx == `MMBX_IDX_M)
        m_or_reg <= wr_val[15:0]; // see RQ3
      else if (wr_en)
        regs_mem[wr_idx] <= wr_val;
      if (sp_we)
        spad_mem[sp_adr] <= rd(dst); // see RQ9
    end
  end

  // ==========================================================
  // Event outputs
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      reject_o    <= 1'b0;
      skip_o      <= 1'b0;
      carry_o     <= 1'b0;
      borrow_o    <= 1'b0;
      rej_cnt_reg <= 8'h00;
    end else begin
      reject_o <= rej;
      skip_o   <= skip;
      carry_o  <= cy;
      borrow_o <= bw;
      if (rej)
        rej_cnt_reg <= rej_cnt_reg + 8'h01;
      else if (bus_i.wr && bus_i.addr == `MMBX_OFS_STAT)
        rej_cnt_reg <= 8'h00;
    end
  end

  // ==========================================================
  // Register bus
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      step_reg    <= 1'b0;
      cpl_reg     <= `MMBX_CPL_RST;
      didx_reg    <= 6'h00;
      bus_rdata_o <= 32'h00000000;
    end else begin
      if (bus_i.wr && bus_i.addr == `MMBX_OFS_CTRL)
        step_reg <= bus_i.wdata[0];
      if (bus_i.wr && bus_i.addr == `MMBX_OFS_CPL)
        cpl_reg <= bus_i.wdata[4:0];
      if (bus_i.wr && bus_i.addr == `MMBX_OFS_DIDX)
        didx_reg <= bus_i.wdata[5:0];
      bus_rdata_o <= 32'h00000000;
      if (bus_i.rd) begin
        case (bus_i.addr)
          `MMBX_OFS_CTRL:  bus_rdata_o <= {31'h00000000, step_reg};
          `MMBX_OFS_CPL:   bus_rdata_o <= {27'h0000000, cpl_reg};
          `MMBX_OFS_PC:    bus_rdata_o <= {16'h0000, pc_reg};
          `MMBX_OFS_STAT:  bus_rdata_o <= {15'h0000, busy_o, rej_cnt_reg, m_or_reg[7:0]};
          `MMBX_OFS_DIDX:  bus_rdata_o <= {26'h0000000, didx_reg};
          `MMBX_OFS_DDATA: bus_rdata_o <= {8'h00, rd(didx_reg)};
          default:         bus_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  port_command_reg_src_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ5
    accept && op == `MMBX_OP_RMOVE && src == `MMBX_IDX_PORT_COMMAND_REG |=> reject_o)
    else $error("command register accepted as source");
  data_dst_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ6
    accept && op == `MMBX_OP_RMOVE && src == `MMBX_IDX_DATA && dst == `MMBX_IDX_PORT_COMMAND_REG
    |=> reject_o && $stable(regs_mem[`MMBX_IDX_PORT_COMMAND_REG]))
    else $error("data to command move not rejected");
  cond_keep_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ10
    accept && op == `MMBX_OP_MANIP && is_cond(dst) |-> !wr_en)
    else $error("manipulate wrote a condition register");
  skip_zero_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ13
    accept && op == `MMBX_OP_SKIP && msk == 4'h0 &&
    (cur[7:5] == 3'h1 || cur[7:5] == 3'h3 || cur[7:5] == 3'h4)
    |=> skip_o && pc_o == $past(pc_o) + 16'h0002)
    else $error("zero mask skip missed");
  noskip_zero_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ14
    accept && op == `MMBX_OP_SKIP && msk == 4'h0 &&
    (cur[7:5] == 3'h0 || cur[7:5] == 3'h5 || cur[7:5] == 3'h7)
    |=> !skip_o && pc_o == $past(pc_o) + 16'h0001)
    else $error("zero mask skipped wrongly");
  lit_pc_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ23
    accept && op == `MMBX_OP_LIT24 |=> pc_o == $past(pc_o) + 16'h0002)
    else $error("literal word not stepped over");
  len_fix_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ18, RQ19
    accept && op == `MMBX_OP_MEM && cur[11] && cur[4:0] == `MMBX_FL_BADECC && !rej
    |=> mem_req_o.valid && mem_req_o.len == `MMBX_FL_FULL && mem_req_o.no_log &&
        mem_req_o.bad_ecc)
    else $error("length 26 write mishandled");
  cpl_len_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ17
    accept && op == `MMBX_OP_MEM && cur[4:0] == 5'h00 && !rej && cpl_reg <= `MMBX_FL_FULL
    |=> mem_req_o.len == $past(cpl_reg))
    else $error("zero length did not use CURRENT_PRECISION_LENGTH");
  timer_clr_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see RQ22
    accept && op == `MMBX_OP_LIT8 && cur[11:8] == 4'hE
    |=> regs_mem[`MMBX_IDX_TIMR] == 24'h000000)
    else $error("timer not cleared by literal");
endmodule // mmbx_exec

// file: test/mmbx_mem_model.sv
// Behavioural main memory that answers the executor's field requests
`timescale 1ns/1ps
module mmbx_mem_model (
  input  wire logic                clk_sys_i,
  input  wire logic                reset_n_i,
  input  wire mmbx_pkg::mmbx_mem_t req_i,
  input  wire logic [3:0]          lat_i,
  output logic                     ack_o = 1'b0,
  output logic [23:0]              rdata_o = 24'h5A5A5A
);
  // ==========================================
  // Storage and answer timing
  logic [23:0] mem_q [16];
  logic [3:0]  wait_q;
  logic        done_q;
  always_ff @(posedge clk_sys_i) begin
    ack_o <= 1'b0;
    // Lines toggle outside the ack cycle, so a late sample never sees stale data
    rdata_o <= ~rdata_o;
    if (!reset_n_i) begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else if (req_i.valid && !done_q) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q == lat_i) begin
        ack_o <= 1'b1;
        done_q <= 1'b1;
        wait_q <= 4'h0;
        if (req_i.write) begin
          mem_q[req_i.addr[3:0]] <= req_i.data;
        end else begin
          rdata_o <= mem_q[req_i.addr[3:0]];
        end
      end
    end else begin
      // One idle cycle after ack while the request drops
      done_q <= 1'b0;
    end
  end
endmodule // mmbx_mem_model

// file: test/testbench.sv
// Self-checking bench for the move, branch and memory micro executor
`timescale 1ns/1ps
`include "mmbx_consts.svh"
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
      miscompares++; \
      $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module testbench;
  // ==========================================
  // Signals
  logic                 clk_sys_i;
  logic                 reset_n_i;
  logic                 instr_valid_i;
  logic [15:0]          instr_i;
  logic [15:0]          literal_i;
  mmbx_pkg::mmbx_cond_t cond_i;
  logic                 mem_ack_i;
  logic [23:0]          mem_rdata_i;
  mmbx_pkg::mmbx_bus_t  bus_i;
  logic [31:0]          bus_rdata_o;
  mmbx_pkg::mmbx_mem_t  mem_req_o, req_seen, req_exp;
  logic [15:0]          pc_o, pc_was;
  logic                 busy_o, reject_o, skip_o, carry_o, borrow_o;
  logic                 rej, skp, cy, bw;
  logic [3:0]           lat;
  logic [31:0]          rd_val;
  int                   miscompares, num_checks;
  logic [15:0] bad [13] = '{{4'h1, 6'h15, 6'h12}, {4'h1, 6'h36, 6'h12}, {4'h1, 6'h27, 6'h12},
    {4'h1, 6'h03, 6'h12}, {4'h1, 6'h2D, 6'h12}, {4'h1, 6'h12, 6'h33}, {4'h1, 6'h33, 6'h2F},
    {4'h1, 6'h2F, 6'h2F}, {4'h1, 6'h3A, 6'h12}, {4'h1, 6'h12, 6'h3A}, {4'h2, 6'h33, 6'h03},
    {4'h8, 4'hD, 8'h11}, {4'h9, 4'hF, 8'h11}};
  logic [31:0] br [4] = '{{4'h4, 6'h15, 2'd1, 4'hE, 16'hFFFF}, {4'h4, 6'h15, 2'd0, 4'hE, 16'h1},
    {4'h5, 6'h15, 2'd2, 4'h3, 16'h4}, {4'h5, 6'h15, 2'd3, 4'h3, 16'h1}};
  logic [16:0] sk [4] = '{{4'h6, 4'h5, 3'd3, 5'h0B, 1'b1}, {4'h6, 4'h5, 3'd4, 5'h0B, 1'b1},
    {4'h6, 4'h5, 3'd3, 5'h0B, 1'b1}, {4'h6, 4'hA, 3'd0, 5'h0B, 1'b0}};
  logic [35:0] mw [5] = '{{5'd24, 5'd24, 24'hABCDEF, 2'b00}, {5'd8, 5'd8, 24'h0000EF, 2'b00},
    {5'd0, 5'd12, 24'h000DEF, 2'b00}, {5'd25, 5'd24, 24'hABCDEF, 2'b10},
    {5'd26, 5'd24, 24'hABCDEF, 2'b11}};

  mmbx_exec i_dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .literal_i(literal_i), .cond_i(cond_i), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .bus_i(bus_i), .bus_rdata_o(bus_rdata_o),
    .mem_req_o(mem_req_o), .pc_o(pc_o), .busy_o(busy_o), .reject_o(reject_o),
    .skip_o(skip_o), .carry_o(carry_o), .borrow_o(borrow_o));
  mmbx_mem_model i_mem (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_i(mem_req_o), .lat_i(lat),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  // ==========================================
  // Access tasks
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i);
    bus_i <= '0;
    #1;
  endtask
  task automatic bus_rd(input logic [4:0] a);
    @(posedge clk_sys_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys_i);
    bus_i <= '0;
    #1;
    rd_val = bus_rdata_o;
  endtask
  task automatic dbg(input logic [5:0] idx);
    bus_wr(`MMBX_OFS_DIDX, {26'h0, idx});
    bus_rd(`MMBX_OFS_DDATA);
  endtask
  // Issues one micro, samples the pulses, then waits out any memory access
  task automatic exec(input logic [15:0] ins, input logic [15:0] lit);
    pc_was = pc_o;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b1;
    instr_i <= ins;
    literal_i <= lit;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    #1;
    {rej, skp, cy, bw} = {reject_o, skip_o, carry_o, borrow_o};
    req_seen = mem_req_o;
    for (int i = 0; i < 40 && busy_o !== 1'b0; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (busy_o !== 1'b0) begin
      $display("Error memory wait expected 0 seen 1");
      miscompares++;
      tally_and_finish();
    end
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // ==========================================
  // Test sequence
  initial begin
    reset_n_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    literal_i = 16'h0000;
    cond_i = 20'h50000;
    bus_i = '0;
    lat = 4'h0;
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    bus_rd(`MMBX_OFS_CPL);
    `CHK("cpl reset", 32'h18, rd_val)
    bus_rd(5'h1C);
    `CHK("unmapped read", 32'h0, rd_val)
    bus_wr(`MMBX_OFS_PC, 32'h40);
    `CHK("pc write", 16'h40, pc_o)
    $display("Test bus done");
    exec({4'h9, 4'h4, 8'hAB}, 16'hCDEF);
    `CHK("lit24 pc step", 16'h2, pc_o - pc_was)
    dbg(6'h12);
    `CHK("lit24 value", 32'hABCDEF, rd_val)
    exec({4'h1, 6'h30, 6'h12}, 16'h0);
    dbg(6'h30);
    `CHK("wide to narrow", 32'hF, rd_val)
    exec({4'h1, 6'h16, 6'h30}, 16'h0);
    dbg(6'h16);
    `CHK("narrow to wide", 32'hF, rd_val)
    dbg(6'h12);
    `CHK("source kept", 32'hABCDEF, rd_val)
    exec({4'h8, 4'h5, 8'hAB}, 16'h0);
    dbg(6'h16);
    `CHK("lit8 zero fill", 32'hAB, rd_val)
    exec({4'h8, 4'hE, 8'h77}, 16'h0);
    dbg(6'h3A);
    `CHK("timer cleared", 32'h0, rd_val)
    $display("Test moves done");
    exec({4'h1, 6'h30, 6'h16}, 16'h0);
    exec({4'h2, 6'h12, 2'b00, 4'h3}, 16'h0);
    exec({4'h2, 6'h30, 2'b01, 4'h3}, 16'h0);
    exec({4'h2, 6'h16, 2'b10, 4'h3}, 16'h0);
    exec({4'h2, 6'h1A, 2'b11, 4'h3}, 16'h0);
    dbg(6'h16);
    `CHK("spad left", 32'hABCDEF, rd_val)
    dbg(6'h1A);
    `CHK("spad right", 32'hB, rd_val)
    exec({4'h8, 4'hF, 8'h50}, 16'h0);
    exec({4'h8, 4'h5, 8'h03}, 16'h0);
    dbg(6'h16);
    `CHK("m or next", 32'h53, rd_val)
    $display("Test scratchpad done");
    bus_wr(`MMBX_OFS_STAT, 32'h0);
    foreach (bad[i]) begin
      exec(bad[i], 16'h0);
      `CHK("refused", 1'b1, rej)
    end
    bus_wr(`MMBX_OFS_CTRL, 32'h1);
    exec({4'h1, 6'h16, 6'h27}, 16'h0);
    `CHK("u in step", 1'b1, rej)
    bus_wr(`MMBX_OFS_CTRL, 32'h0);
    exec({4'h1, 6'h16, 6'h27}, 16'h0);
    `CHK("u no step", 1'b0, rej)
    bus_rd(`MMBX_OFS_STAT);
    `CHK("reject count", 8'h0E, rd_val[15:8])
    $display("Test refusals done");
    foreach (br[i]) begin
      exec(br[i][31:16], 16'h0);
      `CHK("branch pc", br[i][15:0], pc_o - pc_was)
    end
    for (int v = 0; v < 8; v++) begin
      exec({4'h6, 4'h0, 3'(v), 5'h0B}, 16'h0);
      `CHK("zero mask", (v >= 1 && v <= 4) ? 17'h10002 : 17'h1, {skp, pc_o - pc_was})
    end
    foreach (sk[i]) begin
      exec(sk[i][16:1], 16'h0);
      `CHK("mask skip", sk[i][0], skp)
    end
    exec({4'h3, 6'h15, 2'd1, 4'hF}, 16'h0);
    `CHK("manip add", 4'b0110, {rej, skp, cy, bw})
    exec({4'h3, 6'h15, 2'd2, 4'h6}, 16'h0);
    `CHK("manip sub", 4'b0101, {rej, skp, cy, bw})
    exec({4'h3, 6'h16, 2'd0, 4'h9}, 16'h0);
    exec({4'h3, 6'h16, 2'd3, 4'hF}, 16'h0);
    dbg(6'h16);
    `CHK("manip load xor", 32'h6, rd_val)
    dbg(`MMBX_IDX_CARRY);
    `CHK("cond kept", 32'h5, rd_val)
    $display("Test branch and skip done");
    exec({4'h9, 4'h7, 8'h00}, 16'h0123);
    bus_wr(`MMBX_OFS_CPL, 32'hC);
    foreach (mw[i]) begin
      lat = i[0] ? 4'h5 : 4'h0;
      exec({4'h7, 1'b1, 1'b0, 4'h4, 1'b0, mw[i][35:31]}, 16'h0);
      req_exp = '{valid: 1'b1, write: 1'b1, dir: 1'b0, len: mw[i][30:26], addr: 24'h123,
        data: mw[i][25:2], no_log: mw[i][1], bad_ecc: mw[i][0]};
      `CHK("mem write", req_exp, req_seen)
      `CHK("mem pc", 16'h1, pc_o - pc_was)
    end
    exec({4'h7, 1'b0, 1'b0, 4'h5, 1'b0, 5'd8}, 16'h0);
    `CHK("mem read len", 6'h08, {req_seen.write, req_seen.len})
    dbg(6'h16);
    `CHK("mem read fill", 32'hEF, rd_val)
    $display("Test memory done");
    tally_and_finish();
  end
endmodule // testbench
